// file: rtl/nfpi_regs.svh
// register map, field positions, reset values and timing constants
`ifndef NFPI_REGS_SVH
`define NFPI_REGS_SVH
`define NFPI_A_MODE    4'h0
`define NFPI_A_RATE    4'h1
`define NFPI_A_SET     4'h2
`define NFPI_A_OPCTL   4'h3
`define NFPI_A_CNT1    4'h4
`define NFPI_A_CNT2    4'h5
`define NFPI_A_GPT     4'h6
`define NFPI_A_NRT     4'h7
`define NFPI_A_MRT     4'h8
`define NFPI_A_FLAGS   4'h9
`define NFPI_A_FIFO    4'hA
`define NFPI_A_CMD     4'hB
`define NFPI_A_STAT    4'hC
`define NFPI_M_ISOA    2'h0
`define NFPI_M_RDR     2'h1
`define NFPI_M_ACT     2'h2
`define NFPI_B_TARG    2
`define NFPI_B_AUTO    3
`define NFPI_R_128     2'h0
`define NFPI_B_TFE     0
`define NFPI_B_AM      1
`define NFPI_B_PM      2
`define NFPI_B_FDEN    3
`define NFPI_B_RXEN    0
`define NFPI_B_TXEN    1
`define NFPI_F_CAT     0
`define NFPI_F_EON     1
`define NFPI_F_EOF     2
`define NFPI_F_NRE     3
`define NFPI_F_SFE     4
`define NFPI_F_CRC     5
`define NFPI_F_TXD     6
`define NFPI_F_COL     7
`define NFPI_C_TXCRC   8'hC4
`define NFPI_C_PRESET  8'hCC
`define NFPI_C_INITON  8'hC8
`define NFPI_C_RESPON  8'hC9
`define NFPI_RST_SET   8'h06
`define NFPI_START     8'hF0
`define NFPI_CRC_INIT  16'h6363
`define NFPI_TMR_SHIFT 4
`define NFPI_CLK_NS    100
`define NFPI_IGT_NS    5000
`define NFPI_RGT_NS    1000
`define NFPI_IGT_CYC   ((`NFPI_IGT_NS + `NFPI_CLK_NS - 1) / `NFPI_CLK_NS)
`define NFPI_RGT_CYC   ((`NFPI_RGT_NS + `NFPI_CLK_NS - 1) / `NFPI_CLK_NS)
`endif

// file: rtl/nfpi_pkg.sv
// types shared by the initiator control block
package nfpi_pkg;
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} nfpi_byte_t;
	typedef struct packed {
		logic       start;
		logic       valid;
		logic [7:0] data;
		logic       last;
	} nfpi_rx_t;
	typedef enum logic [2:0] {T_IDLE, T_SB, T_LEN, T_DATA, T_CRC1, T_CRC2, T_END} nfpi_tx_state_t;
	typedef enum logic [3:0] {A_IDLE, A_IGUARD, A_ON, A_HOLD, A_NRT, A_MRT, A_RX, A_RCA, A_RGUARD} nfpi_act_state_t;
endpackage

// file: rtl/nfpi_initiator_ctrl.sv
// initiator control: mode/rate selection, 106k transport framing, active field handshake
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/100ps
`include "nfpi_regs.svh"

module nfpi_initiator_ctrl (
	input  wire logic               clk_sys,
	input  wire logic               rstn,
	input  wire logic [3:0]         addr,
	input  wire logic [7:0]         wdata,
	input  wire logic               wrStb,
	input  wire logic               rdStb,
	output logic      [7:0]         rdata,
	input  wire logic               extFieldPin,
	input  wire nfpi_pkg::nfpi_rx_t rxLink,
	output nfpi_pkg::nfpi_byte_t    txLink,
	input  wire logic               txReady,
	output logic                    txEnable,
	output logic                    rxEnable,
	output logic                    amEnable,
	output logic                    pmEnable,
	output logic                    fieldDetEnable,
	output logic                    caThreshold,
	output logic      [1:0]         txRate,
	output logic      [1:0]         rxRate
);
	// ----------------------------------------
	// registers and decode
	// ----------------------------------------
	logic [7:0] modeReg, rateReg, setReg, opReg, cnt1, cnt2, gpReg, nrtReg, mrtReg, flags;
	logic [7:0] mem [0:15];
	logic [4:0] wp, rp;
	logic       ext1, extField;
	logic       fieldOnA, rxWatch, txDone;
	logic [15:0] txCrc, rxCrc, tmr;
	logic [12:0] remain;
	logic       rxFirst;
	logic [7:0] setF, clrF;
	nfpi_pkg::nfpi_tx_state_t  tState;
	nfpi_pkg::nfpi_act_state_t aState;

	wire        wrMode   = wrStb && addr == `NFPI_A_MODE;
	wire        wrSet    = wrStb && addr == `NFPI_A_SET;
	wire        wrOp     = wrStb && addr == `NFPI_A_OPCTL;
	wire        cmdWr    = wrStb && addr == `NFPI_A_CMD;
	wire        cmdTx    = cmdWr && wdata == `NFPI_C_TXCRC;
	wire        cmdPre   = cmdWr && wdata == `NFPI_C_PRESET;
	wire        cmdInit  = cmdWr && wdata == `NFPI_C_INITON;
	wire        cmdResp  = cmdWr && wdata == `NFPI_C_RESPON;
	wire [1:0]  modeSel  = modeReg[1:0];
	wire        active   = modeSel == `NFPI_M_ACT && !modeReg[`NFPI_B_TARG];
	wire        autoResp = modeReg[`NFPI_B_AUTO];
	wire        tfActive = setReg[`NFPI_B_TFE] && modeSel == `NFPI_M_ISOA && rateReg[1:0] == `NFPI_R_128
		&& rateReg[3:2] == `NFPI_R_128 || setReg[`NFPI_B_TFE] && active;
	wire [12:0] txCount  = {cnt2[4:0], cnt1};
	wire        fifoFull = (wp[3:0] == rp[3:0]) && (wp[4] != rp[4]);
	wire        fifoEmpty = wp == rp;
	wire        hostPush = wrStb && addr == `NFPI_A_FIFO;
	wire        hostPop  = rdStb && addr == `NFPI_A_FIFO && !fifoEmpty;
	wire        rxAccept = active ? rxWatch : opReg[`NFPI_B_RXEN];
	// length and data go to the FIFO, start byte does not when framing is on
	wire        rxStore  = rxAccept && rxLink.valid && !(tfActive && rxFirst);
	wire        txLoad   = !txLink.valid && tState == nfpi_pkg::T_DATA && remain != 13'h0000;
	wire        push     = (hostPush || rxStore) && !fifoFull;
	wire [7:0]  pushData = rxStore ? rxLink.data : wdata;
	wire        pop      = hostPop || txLoad;
	// reader 212/424 mode uses the transmit rate for reception
	wire [1:0]  next_rxRate = modeSel == `NFPI_M_RDR || active ? rateReg[1:0] : rateReg[3:2];
	// preset in active mode turns on transport framing
	wire [7:0]  presetSet = active ? (setReg | (8'h01 << `NFPI_B_TFE) | (8'h01 << `NFPI_B_AM))
		& ~(8'h01 << `NFPI_B_PM) : (setReg | (8'h01 << `NFPI_B_AM)) & ~(8'h01 << `NFPI_B_PM);
	wire [7:0]  next_setRaw = wrSet ? wdata : cmdPre ? presetSet : setReg;
	// detector enable forced in peer mode
	wire [7:0]  next_setReg = next_setRaw | ({7'h00, active} << `NFPI_B_FDEN);
	// passive field switch-on refused while an external field is present
	// in active mode the transmitter bit belongs to the field-on sequencer
	wire        next_txBit = active ? fieldOnA : wrOp ? wdata[`NFPI_B_TXEN] && (!extField
		|| opReg[`NFPI_B_TXEN]) : opReg[`NFPI_B_TXEN];
	wire [7:0]  next_opReg = {wrOp ? wdata[7:2] : opReg[7:2], next_txBit,
		wrOp ? wdata[`NFPI_B_RXEN] : opReg[`NFPI_B_RXEN]};
	wire [15:0] gpLimit  = {8'h00, gpReg} << `NFPI_TMR_SHIFT;
	wire [15:0] nrtLimit = {8'h00, nrtReg} << `NFPI_TMR_SHIFT;
	wire [15:0] mrtLimit = {8'h00, mrtReg} << `NFPI_TMR_SHIFT;
	wire [7:0]  statVal  = {3'h0, tState != nfpi_pkg::T_IDLE, rxWatch, opReg[`NFPI_B_TXEN], fifoEmpty, extField};
	wire [7:0]  rdMux    =
		addr == `NFPI_A_MODE  ? modeReg :
		addr == `NFPI_A_RATE  ? rateReg :
		addr == `NFPI_A_SET   ? setReg  :
		addr == `NFPI_A_OPCTL ? opReg   :
		addr == `NFPI_A_CNT1  ? cnt1    :
		addr == `NFPI_A_CNT2  ? cnt2    :
		addr == `NFPI_A_GPT   ? gpReg   :
		addr == `NFPI_A_NRT   ? nrtReg  :
		addr == `NFPI_A_MRT   ? mrtReg  :
		addr == `NFPI_A_FLAGS ? flags   :
		addr == `NFPI_A_FIFO  ? mem[rp[3:0]] :
		addr == `NFPI_A_STAT  ? statVal : 8'h00;

	function automatic logic [15:0] crcNext(input logic [15:0] c, input logic [7:0] d);
		logic [7:0] b;
		b = d ^ c[7:0];
		b = b ^ {b[3:0], 4'h0};
		crcNext = {8'h00, c[15:8]} ^ {b, 8'h00} ^ {5'h00, b, 3'h0} ^ {12'h000, b[7:4]};
	endfunction

	// ----------------------------------------
	// host registers
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			modeReg <= 8'h00;
			rateReg <= 8'h00;
			setReg  <= `NFPI_RST_SET;
			opReg   <= 8'h00;
			cnt1    <= 8'h00;
			cnt2    <= 8'h00;
			gpReg   <= 8'h00;
			nrtReg  <= 8'h00;
			mrtReg  <= 8'h00;
			flags   <= 8'h00;
			rdata   <= 8'h00;
		end else begin
			if (wrMode) modeReg <= wdata;
			if (wrStb && addr == `NFPI_A_RATE) rateReg <= wdata;
			if (wrStb && addr == `NFPI_A_CNT1) cnt1 <= wdata;
			if (wrStb && addr == `NFPI_A_CNT2) cnt2 <= wdata;
			if (wrStb && addr == `NFPI_A_GPT) gpReg <= wdata;
			if (wrStb && addr == `NFPI_A_NRT) nrtReg <= wdata;
			if (wrStb && addr == `NFPI_A_MRT) mrtReg <= wdata;
			setReg <= next_setReg;
			opReg  <= next_opReg;
			// write one to clear; a new event in the same cycle wins
			flags  <= (flags & ~clrF) | setF;
			rdata  <= rdStb ? rdMux : 8'h00;
		end
	end

	// ----------------------------------------
	// pin sync, fifo, outputs
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ext1           <= 1'b0;
			extField       <= 1'b0;
			wp             <= 5'h00;
			rp             <= 5'h00;
			txEnable       <= 1'b0;
			rxEnable       <= 1'b0;
			amEnable       <= 1'b0;
			pmEnable       <= 1'b0;
			fieldDetEnable <= 1'b0;
			txRate         <= 2'h0;
			rxRate         <= 2'h0;
		end else begin
			ext1     <= extFieldPin;
			extField <= ext1;
			if (push) begin
				mem[wp[3:0]] <= pushData;
				wp <= wp + 5'h01;
			end
			if (pop) rp <= rp + 5'h01;
			txEnable       <= opReg[`NFPI_B_TXEN];
			rxEnable       <= rxAccept;
			amEnable       <= setReg[`NFPI_B_AM];
			pmEnable       <= setReg[`NFPI_B_PM];
			fieldDetEnable <= setReg[`NFPI_B_FDEN];
			txRate         <= rateReg[1:0];
			rxRate         <= next_rxRate;
		end
	end

	// ----------------------------------------
	// transmit framer
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			tState <= nfpi_pkg::T_IDLE;
			txLink <= '0;
			txCrc  <= `NFPI_CRC_INIT;
			remain <= 13'h0000;
			txDone <= 1'b0;
		end else begin
			txDone <= 1'b0;
			if (txLink.valid && txReady) txLink.valid <= 1'b0;
			case (tState)
				nfpi_pkg::T_IDLE: if (cmdTx) begin
					txCrc  <= `NFPI_CRC_INIT;
					remain <= txCount;
					tState <= tfActive ? nfpi_pkg::T_SB : nfpi_pkg::T_DATA;
				end
				// start byte first, outside the CRC
				nfpi_pkg::T_SB: if (!txLink.valid) begin
					txLink <= '{valid: 1'b1, data: `NFPI_START};
					tState <= nfpi_pkg::T_LEN;
				end
				// length is byte count plus one
				nfpi_pkg::T_LEN: if (!txLink.valid) begin
					txLink <= '{valid: 1'b1, data: cnt1 + 8'h01};
					txCrc  <= crcNext(txCrc, cnt1 + 8'h01);
					tState <= nfpi_pkg::T_DATA;
				end
				nfpi_pkg::T_DATA: if (!txLink.valid) begin
					if (remain == 13'h0000) begin
						tState <= nfpi_pkg::T_CRC1;
					end else begin
						txLink <= '{valid: 1'b1, data: mem[rp[3:0]]};
						txCrc  <= crcNext(txCrc, mem[rp[3:0]]);
						remain <= remain - 13'h0001;
					end
				end
				nfpi_pkg::T_CRC1: if (!txLink.valid) begin
					txLink <= '{valid: 1'b1, data: txCrc[7:0]};
					tState <= nfpi_pkg::T_CRC2;
				end
				nfpi_pkg::T_CRC2: if (!txLink.valid) begin
					txLink <= '{valid: 1'b1, data: txCrc[15:8]};
					tState <= nfpi_pkg::T_END;
				end
				nfpi_pkg::T_END: if (!txLink.valid) begin
					txDone <= 1'b1;
					tState <= nfpi_pkg::T_IDLE;
				end
				default: tState <= nfpi_pkg::T_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// receive checker
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rxFirst <= 1'b1;
			rxCrc   <= `NFPI_CRC_INIT;
		end else if (rxAccept && rxLink.start) begin
			rxFirst <= 1'b1;
			rxCrc   <= `NFPI_CRC_INIT;
		end else if (rxAccept && rxLink.valid) begin
			rxFirst <= 1'b0;
			if (rxStore) rxCrc <= crcNext(rxCrc, rxLink.data);
		end
	end

	// ----------------------------------------
	// active field handshake
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			aState      <= nfpi_pkg::A_IDLE;
			tmr         <= 16'h0000;
			fieldOnA    <= 1'b0;
			rxWatch     <= 1'b0;
			caThreshold <= 1'b0;
		end else begin
			tmr <= tmr + 16'h0001;
			case (aState)
				// from idle, the field comes on only through the field-on commands
				nfpi_pkg::A_IDLE: if (active && (cmdInit || cmdResp)) begin
					caThreshold <= 1'b1;
					tmr         <= 16'h0000;
					if (!extField) begin
						fieldOnA <= 1'b1;
						aState   <= cmdInit ? nfpi_pkg::A_IGUARD : nfpi_pkg::A_RGUARD;
					end
				end
				// done after the initial guard time
				nfpi_pkg::A_IGUARD: if (tmr >= 16'(`NFPI_IGT_CYC)) begin
					caThreshold <= 1'b0;
					aState      <= nfpi_pkg::A_ON;
				end
				nfpi_pkg::A_ON: if (txDone) begin
					tmr    <= 16'h0000;
					aState <= nfpi_pkg::A_HOLD;
				end
				// field off after the general timer delay
				nfpi_pkg::A_HOLD: if (tmr >= gpLimit) begin
					fieldOnA <= 1'b0;
					tmr      <= 16'h0000;
					aState   <= nfpi_pkg::A_NRT;
				end
				// wait for target field within the no-response time
				nfpi_pkg::A_NRT: if (extField) begin
					tmr    <= 16'h0000;
					aState <= nfpi_pkg::A_MRT;
				end else if (tmr >= nrtLimit) begin
					aState <= nfpi_pkg::A_IDLE;
				end
				// receiver unmasked once the mask time is over
				nfpi_pkg::A_MRT: if (tmr >= mrtLimit) begin
					rxWatch <= 1'b1;
					aState  <= nfpi_pkg::A_RX;
				end
				// target field drop, optional automatic response
				nfpi_pkg::A_RX: if (!extField) begin
					rxWatch     <= 1'b0;
					caThreshold <= autoResp;
					aState      <= autoResp ? nfpi_pkg::A_RCA : nfpi_pkg::A_IDLE;
				end
				nfpi_pkg::A_RCA: begin
					tmr <= 16'h0000;
					if (extField) begin
						caThreshold <= 1'b0;
						aState      <= nfpi_pkg::A_IDLE;
					end else begin
						fieldOnA <= 1'b1;
						aState   <= nfpi_pkg::A_RGUARD;
					end
				end
				nfpi_pkg::A_RGUARD: if (tmr >= 16'(`NFPI_RGT_CYC)) begin
					caThreshold <= 1'b0;
					aState      <= nfpi_pkg::A_ON;
				end
				default: aState <= nfpi_pkg::A_IDLE;
			endcase
			if (!active) begin
				aState   <= nfpi_pkg::A_IDLE;
				fieldOnA <= 1'b0;
				rxWatch  <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// event flags
	// ----------------------------------------
	wire guardDone = aState == nfpi_pkg::A_IGUARD && tmr >= 16'(`NFPI_IGT_CYC)
		|| aState == nfpi_pkg::A_RGUARD && tmr >= 16'(`NFPI_RGT_CYC);
	wire colHit = extField && (aState == nfpi_pkg::A_RCA
		|| aState == nfpi_pkg::A_IDLE && active && (cmdInit || cmdResp));
	// start byte mismatch raises soft framing error
	wire sfeHit = rxAccept && rxLink.valid && tfActive && rxFirst && rxLink.data != `NFPI_START;
	// residue must be zero after the CRC bytes
	wire crcHit = rxAccept && rxLink.last && rxCrc != 16'h0000;
	always_comb begin
		setF                = 8'h00;
		setF[`NFPI_F_CAT]   = guardDone;
		setF[`NFPI_F_EON]   = aState == nfpi_pkg::A_NRT && extField;
		setF[`NFPI_F_EOF]   = aState == nfpi_pkg::A_RX && !extField;
		setF[`NFPI_F_NRE]   = aState == nfpi_pkg::A_NRT && !extField && tmr >= nrtLimit;
		setF[`NFPI_F_SFE]   = sfeHit;
		setF[`NFPI_F_CRC]   = crcHit;
		setF[`NFPI_F_TXD]   = txDone;
		setF[`NFPI_F_COL]   = colHit;
		clrF                = (wrStb && addr == `NFPI_A_FLAGS) ? wdata : 8'h00;
	end

endmodule // nfpi_initiator_ctrl

// file: test/nfpi_initiator_ctrl_properties.sv
// port-level checks of the initiator control block
`timescale 1ns/100ps
`include "nfpi_regs.svh"
module nfpi_initiator_ctrl_properties (
	input wire logic                 clk_sys,
	input wire logic                 rstn,
	input wire logic [3:0]           addr,
	input wire logic [7:0]           wdata,
	input wire logic                 wrStb,
	input wire logic                 rdStb,
	input wire logic [7:0]           rdata,
	input wire logic                 extFieldPin,
	input wire nfpi_pkg::nfpi_rx_t   rxLink,
	input wire nfpi_pkg::nfpi_byte_t txLink,
	input wire logic                 txReady,
	input wire logic                 txEnable,
	input wire logic                 rxEnable,
	input wire logic                 amEnable,
	input wire logic                 pmEnable,
	input wire logic                 fieldDetEnable,
	input wire logic                 caThreshold,
	input wire logic [1:0]           txRate,
	input wire logic [1:0]           rxRate
);
	// ----------------
	// shadow of host writes
	// ----------------
	logic [1:0] mode;
	logic [3:0] rate;
	logic       tfe;
	logic       inTx;
	logic [7:0] cnt1;
	logic [7:0] txIdx;
	logic [3:0] extHist;
	wire        wrCmd  = wrStb && addr == `NFPI_A_CMD;
	wire        actOn  = mode == `NFPI_M_ACT;
	wire        quiet  = extHist == 4'h0 && !extFieldPin;
	wire        framed = tfe && mode == `NFPI_M_ISOA && rate == 4'h0;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mode <= 2'h0;
			rate <= 4'h0;
			tfe <= 1'b0;
			inTx <= 1'b0;
			cnt1 <= 8'h00;
			txIdx <= 8'h00;
			extHist <= 4'h0;
		end else begin
			extHist <= {extHist[2:0], extFieldPin};
			if (wrStb && addr == `NFPI_A_MODE)
				mode <= wdata[1:0];
			if (wrStb && addr == `NFPI_A_RATE)
				rate <= wdata[3:0];
			if (wrStb && addr == `NFPI_A_SET)
				tfe <= wdata[`NFPI_B_TFE];
			if (wrStb && addr == `NFPI_A_CNT1)
				cnt1 <= wdata;
			// byte index restarts at each transmit command
			if (wrCmd && wdata == `NFPI_C_TXCRC) begin
				inTx <= framed;
				txIdx <= 8'h00;
			end else if (txLink.valid && txReady)
				txIdx <= txIdx + 8'h01;
		end
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	property p_txHold;
		txLink.valid && !txReady |=> txLink.valid && $stable(txLink.data);
	endproperty
	a_txHold: assert property (p_txHold) else $error("tx byte dropped early");
	property p_rdIdle;
		!rdStb |=> rdata == 8'h00;
	endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
	property p_refuse;
		extFieldPin [*6] |-> !$rose(txEnable);
	endproperty
	a_refuse: assert property (p_refuse) else $error("field on under external field");
	property p_rates;
		(mode == `NFPI_M_RDR) [*2] |-> rxRate == txRate;
	endproperty
	a_rates: assert property (p_rates) else $error("reader rx rate differs");
	property p_fdAuto;
		actOn [*3] |-> fieldDetEnable;
	endproperty
	a_fdAuto: assert property (p_fdAuto) else $error("detector off in peer mode");
	property p_sb;
		inTx && txLink.valid && txIdx == 8'h00 |-> txLink.data == `NFPI_START;
	endproperty
	a_sb: assert property (p_sb) else $error("bad start byte");
	property p_len;
		inTx && txLink.valid && txIdx == 8'h01 |-> txLink.data == cnt1 + 8'h01;
	endproperty
	a_len: assert property (p_len) else $error("bad length byte");
	property p_preset;
		wrCmd && wdata == `NFPI_C_PRESET && actOn |-> ##[1:3] amEnable && !pmEnable;
	endproperty
	a_preset: assert property (p_preset) else $error("preset channels wrong");
	property p_initOn;
		wrCmd && wdata == `NFPI_C_INITON && actOn && quiet |-> ##[1:60] txEnable;
	endproperty
	a_initOn: assert property (p_initOn) else $error("field not switched on");
endmodule // nfpi_initiator_ctrl_properties
bind nfpi_initiator_ctrl nfpi_initiator_ctrl_properties u_props (
	.clk_sys, .rstn, .addr, .wdata, .wrStb, .rdStb, .rdata, .extFieldPin, .rxLink, .txLink,
	.txReady, .txEnable, .rxEnable, .amEnable, .pmEnable, .fieldDetEnable, .caThreshold, .txRate, .rxRate
);

// file: test/nfpi_target_model.sv
// remote target: accepts modulated bytes, drives its field and demodulated frames
`timescale 1ns/100ps
module nfpi_target_model (
	input  wire logic                 clk_sys,
	input  wire nfpi_pkg::nfpi_byte_t txLink,
	input  wire logic                 stallEn,
	output logic                      txReady,
	output logic                      extFieldPin,
	output nfpi_pkg::nfpi_rx_t        rxLink
);
	int         seed = 32'hdc08fe2f;
	logic [7:0] got[$];
	initial begin
		txReady = 1'b0;
		extFieldPin = 1'b0;
		rxLink = '0;
	end
	// random stalls make the byte hold time visible
	always @(posedge clk_sys) begin
		if (txLink.valid && txReady)
			got.push_back(txLink.data);
		txReady <= !stallEn || 1'($random(seed));
	end
	task automatic setField(input logic on);
		@(posedge clk_sys);
		extFieldPin <= on;
	endtask
	// the end marker shows the inverse of the last byte, then idle data holds the last byte
	task automatic send(input logic [7:0] q[$]);
		@(posedge clk_sys);
		rxLink <= '{1'b1, 1'b0, 8'hA5, 1'b0};
		foreach (q[i]) begin
			@(posedge clk_sys);
			rxLink <= '{1'b0, 1'b1, q[i], 1'b0};
		end
		@(posedge clk_sys);
		rxLink <= '{1'b0, 1'b0, ~q[q.size() - 1], 1'b1};
		@(posedge clk_sys);
		rxLink <= '{1'b0, 1'b0, q[q.size() - 1], 1'b0};
	endtask
endmodule // nfpi_target_model

// file: test/nfpi_initiator_ctrl_tb.sv
// self-checking bench for the initiator control block
`timescale 1ns/100ps
`include "nfpi_regs.svh"
module nfpi_initiator_ctrl_tb;
	logic                 clk_sys = 1'b0;
	logic                 rstn = 1'b0;
	logic [3:0]           addr = 4'h0;
	logic [7:0]           wdata = 8'h00;
	logic                 wrStb = 1'b0;
	logic                 rdStb = 1'b0;
	logic                 stallEn = 1'b0;
	logic [7:0]           rdata, v;
	logic                 txReady, txEnable, rxEnable, amEnable, pmEnable;
	logic                 fieldDetEnable, caThreshold, extFieldPin;
	logic [1:0]           txRate, rxRate;
	nfpi_pkg::nfpi_byte_t txLink;
	nfpi_pkg::nfpi_rx_t   rxLink;
	logic [7:0]           exq[$];
	logic [15:0]          crc;
	int                   mismatches = 0;
	int                   checks = 0;
	int                   seed = 32'hdc08fe2f;
	always #50 clk_sys = ~clk_sys;
	nfpi_initiator_ctrl dut (.clk_sys, .rstn, .addr, .wdata, .wrStb, .rdStb, .rdata, .extFieldPin,
		.rxLink, .txLink, .txReady, .txEnable, .rxEnable, .amEnable, .pmEnable, .fieldDetEnable,
		.caThreshold, .txRate, .rxRate);
	nfpi_target_model tm (.clk_sys, .txLink, .stallEn, .txReady, .extFieldPin, .rxLink);
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic doReset;
		rstn <= 1'b0;
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		wrStb <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys);
		wrStb <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys);
		rdStb <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rdStb <= 1'b0;
		@(negedge clk_sys);
		v = rdata;
	endtask
	// flags are write-one-to-clear, so each waited flag is cleared afterwards
	task automatic waitFlag(input int b, input int lim);
		for (int i = 0; i < lim; i++) begin
			rd(`NFPI_A_FLAGS);
			if (v[b] === 1'b1)
				break;
		end
		cmp("flag", 8'h01, {7'h0, v[b]});
		if (v[b] !== 1'b1)
			end_of_test;
		wr(`NFPI_A_FLAGS, 8'h01 << b);
	endtask
	task automatic waitLvl(ref logic s, input logic l, input int lim, input string n);
		for (int i = 0; i < lim && s !== l; i++)
			@(negedge clk_sys);
		cmp(n, {7'h0, l}, {7'h0, s});
		if (s !== l)
			end_of_test;
	endtask
	function automatic logic [15:0] crcA(input logic [15:0] c, input logic [7:0] d);
		logic [7:0] b;
		b = d ^ c[7:0];
		b = b ^ (b << 4);
		return (c >> 8) ^ ({8'h00, b} << 8) ^ ({8'h00, b} << 3) ^ ({8'h00, b} >> 4);
	endfunction
	// reference frame: start, length, payload, crc low then high
	task automatic txFrame(input int n, input logic fr);
		exq = {};
		crc = `NFPI_CRC_INIT;
		if (fr)
			exq = {`NFPI_START, 8'(n + 1)};
		if (fr)
			crc = crcA(crc, 8'(n + 1));
		wr(`NFPI_A_CNT1, 8'(n));
		wr(`NFPI_A_CNT2, 8'h00);
		for (int i = 0; i < n; i++) begin
			v = 8'($random(seed));
			exq.push_back(v);
			crc = crcA(crc, v);
			wr(`NFPI_A_FIFO, v);
		end
		tm.got = {};
		wr(`NFPI_A_CMD, `NFPI_C_TXCRC);
		waitFlag(`NFPI_F_TXD, 80);
		if (fr)
			exq.push_back(crc[7:0]);
		if (fr)
			exq.push_back(crc[15:8]);
		cmp("tx count", 8'(exq.size() + (fr ? 0 : 2)), 8'(tm.got.size()));
		foreach (exq[i])
			cmp("tx byte", exq[i], tm.got[i]);
	endtask
	task automatic rxFrame(input logic [7:0] sb, input int n);
		logic [7:0] q[$];
		doReset;
		wr(`NFPI_A_SET, 8'h07);
		wr(`NFPI_A_OPCTL, 8'h01);
		q = {sb, 8'(n + 1)};
		crc = crcA(`NFPI_CRC_INIT, q[1]);
		for (int i = 0; i < n; i++) begin
			q.push_back(8'($random(seed)));
			crc = crcA(crc, q[i + 2]);
		end
		q.push_back(crc[7:0]);
		q.push_back(crc[15:8]);
		tm.send(q);
		for (int i = 1; i <= n + 1; i++) begin
			rd(`NFPI_A_FIFO);
			cmp("rx fifo", q[i], v);
		end
		rd(`NFPI_A_FLAGS);
		cmp("rx flags", sb == `NFPI_START ? 8'h00 : 8'h10, v & 8'h30);
	endtask
	initial begin
		doReset;
		rd(`NFPI_A_SET);
		cmp("set reset", `NFPI_RST_SET, v);
		cmp("demod reset", 8'h03, {6'h0, amEnable, pmEnable});
		rd(4'hF);
		cmp("unmapped", 8'h00, v);
		wr(`NFPI_A_MODE, 8'h00);
		wr(`NFPI_A_RATE, 8'h00);
		wr(`NFPI_A_SET, 8'h07);
		stallEn <= 1'b1;
		txFrame(1, 1'b1);
		txFrame(6, 1'b1);
		wr(`NFPI_A_RATE, 8'h05);
		txFrame(3, 1'b0);
		$display("test transmit done");
		rxFrame(`NFPI_START, 4);
		rxFrame(8'h0F, 3);
		$display("test receive done");
		wr(`NFPI_A_MODE, 8'h01);
		for (int r = 1; r <= 2; r++) begin
			wr(`NFPI_A_RATE, 8'(r));
			repeat (3) @(negedge clk_sys);
			cmp("rx rate", 8'(r), {6'h0, rxRate});
			cmp("tx rate", 8'(r), {6'h0, txRate});
		end
		wr(`NFPI_A_MODE, 8'h00);
		tm.setField(1'b1);
		repeat (6) @(posedge clk_sys);
		wr(`NFPI_A_OPCTL, 8'h02);
		rd(`NFPI_A_STAT);
		cmp("tx refused", 8'h00, {7'h0, v[`NFPI_B_TXEN + 1]});
		tm.setField(1'b0);
		$display("test passive done");
		doReset;
		wr(`NFPI_A_MODE, 8'h0A);
		wr(`NFPI_A_CMD, `NFPI_C_PRESET);
		rd(`NFPI_A_SET);
		cmp("preset set", 8'h03, {5'h0, v[2:0]});
		cmp("preset demod", 8'h02, {6'h0, amEnable, pmEnable});
		cmp("detector", 8'h01, {7'h0, fieldDetEnable});
		wr(`NFPI_A_GPT, 8'h01);
		wr(`NFPI_A_NRT, 8'h08);
		wr(`NFPI_A_MRT, 8'h01);
		wr(`NFPI_A_CMD, `NFPI_C_INITON);
		rd(`NFPI_A_FLAGS);
		cmp("early done", 8'h00, {7'h0, v[`NFPI_F_CAT]});
		cmp("ca threshold", 8'h01, {7'h0, caThreshold});
		waitFlag(`NFPI_F_CAT, 60);
		cmp("peer threshold", 8'h00, {7'h0, caThreshold});
		cmp("field on", 8'h01, {7'h0, txEnable});
		txFrame(2, 1'b1);
		waitLvl(txEnable, 1'b0, 60, "field off");
		tm.setField(1'b1);
		repeat (6) @(negedge clk_sys);
		cmp("rx masked", 8'h00, {7'h0, rxEnable});
		waitLvl(rxEnable, 1'b1, 60, "rx watch");
		waitFlag(`NFPI_F_EON, 20);
		tm.setField(1'b0);
		waitFlag(`NFPI_F_EOF, 20);
		waitFlag(`NFPI_F_CAT, 40);
		cmp("response on", 8'h01, {7'h0, txEnable});
		wr(`NFPI_A_MODE, 8'h02);
		txFrame(1, 1'b1);
		waitFlag(`NFPI_F_NRE, 150);
		$display("test active done");
		end_of_test;
	end
endmodule // nfpi_initiator_ctrl_tb
